/* rtl/sspd_defs.svh */
// constants of the serial-to-parallel sink driver
// Overview of operation
// - an 8-bit serial shift stage feeds an 8-bit storage stage
// - each rising shift clock edge while shift clear is high advances the stage and captures the serial bit
// - each rising latch clock edge queues the whole shift stage for storage; an edge while the queue is full is dropped
// - while shift clear is low every shift stage bit is held at zero
// - queued words reach the storage stage only while shift clear is high
// - while output enable is high every buffer bit is low, all sinks off
// - while output enable is low the buffer follows the storage stage
// - the last shift stage bit drives the serial cascade output
// - a low buffer bit turns its sink off, a high bit turns it on
`ifndef SSPD_DEFS_SVH
`define SSPD_DEFS_SVH

`define SSPD_WIDTH       8
`define SSPD_LAST_STAGE  7
`define SSPD_FIFO_DEPTH  8
`define SSPD_ZERO_WORD   8'h00
`define SSPD_SYNC_IDLE   1'h0
`define SSPD_OE_N_IDLE   1'h1
`define SSPD_FRESH_SET   1'h1
`define SSPD_FRESH_DONE  1'h0

`endif

/* rtl/sspd_pkg.sv */
// types shared by the serial-to-parallel sink driver
`include "sspd_defs.svh"

package sspd_pkg;

   // one parallel word of the shift or storage stage
   typedef logic [`SSPD_WIDTH-1:0] sspd_word_t;

   // open-drain sink pins: drive level and enable per output
   typedef struct packed {
      sspd_word_t drive;
      sspd_word_t enable;
   } sspd_sink_t;

endpackage : sspd_pkg

/* rtl/sspd_driver.sv */
// serial-to-parallel sink driver: latch fifo and top level
`include "sspd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// synchronous fifo between latch events and the storage stage
module sspd_fifo #(
   parameter int WIDTH = `SSPD_WIDTH,
   parameter int DEPTH = `SSPD_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   wire              push;
   wire              pop;
   wire  [PW-1:0]    next_wr_ptr;
   wire  [PW-1:0]    next_rd_ptr;

   // flags come from the count, so full and empty are exact
   assign in_ready    = (count != CW'(DEPTH));
   assign out_valid   = (count != '0);
   assign out_data    = mem[rd_ptr];
   assign push        = in_valid & in_ready;
   assign pop         = out_valid & out_ready;
   assign next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
   assign next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);

   // storage array, written only on an accepted push
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= next_wr_ptr;
         if (pop) rd_ptr <= next_rd_ptr;
         if (push != pop) count <= push ? CW'(count + 1'b1) : CW'(count - 1'b1);
      end
   end

   // occupancy never passes the depth
   fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
      count <= CW'(DEPTH))
      else $error("fifo count above depth");

endmodule // sspd_fifo

////////////////////////////////////////////////////////////////////////////////
// top level: shift stage on the shift clock, storage and sinks on sys_clk
module sspd_driver #(
   parameter int WIDTH = `SSPD_WIDTH,
   parameter int DEPTH = `SSPD_FIFO_DEPTH
) (
   // system clock and reset
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   // serial link from the controller
   input  wire logic          shift_stage_clock,
   input  wire logic          serial_input,
   input  wire logic          latch_clock,
   input  wire logic          shift_clear_n,
   input  wire logic          output_enable_n,
   // cascade to the next device, shift clock domain
   output logic               serial_cascade_output,
   // back-pressure on latch events
   output logic               latch_ready,
   // open-drain sink outputs
   output var sspd_pkg::sspd_sink_t sink_output
);

   /////////////////////////////////////////////////////////////////////////////
   // link domain: the shift stage itself
   sspd_pkg::sspd_word_t shift_stage;
   logic                 shift_toggle;
   logic                 shift_fresh;
   wire                  shift_rst_n;

   // clear empties the stage at once, no edge needed
   assign shift_rst_n = resetn & shift_clear_n;

   // serial bit enters stage zero, bits move toward stage seven
   always_ff @(posedge shift_stage_clock or negedge shift_rst_n) begin
      if (!shift_rst_n) begin
         shift_stage <= `SSPD_ZERO_WORD;
      end else begin
         shift_stage <= {shift_stage[`SSPD_LAST_STAGE-1:0], serial_input};
      end
   end

   // event toggle tells the system side a new word is stable
   always_ff @(posedge shift_stage_clock or negedge resetn) begin
      if (!resetn) begin
         shift_toggle <= `SSPD_SYNC_IDLE;
      end else begin
         shift_toggle <= ~shift_toggle;
      end
   end

   // flags an edge whose prior word was wiped by clear or reset; step checks skip it
   always_ff @(posedge shift_stage_clock or negedge shift_rst_n) begin
      if (!shift_rst_n) begin
         shift_fresh <= `SSPD_FRESH_SET;
      end else begin
         shift_fresh <= `SSPD_FRESH_DONE;
      end
   end

   // cascade bit is the last stage flop itself
   assign serial_cascade_output = shift_stage[`SSPD_LAST_STAGE];

   // new word each edge, data enters at stage zero
   shift_advance_a: assert property (@(posedge shift_stage_clock) disable iff (!shift_rst_n)
      !shift_fresh |-> shift_stage == {$past(shift_stage[`SSPD_LAST_STAGE-1:0]), $past(serial_input)})
      else $error("shift stage did not advance");

   // clear holds the stage empty at every edge it spans
   clear_empty_a: assert property (@(posedge shift_stage_clock) disable iff (!resetn)
      !shift_clear_n |-> shift_stage == `SSPD_ZERO_WORD)
      else $error("shift stage not empty under clear");

   // cascade bit carries what stage six held one edge before
   cascade_bit_a: assert property (@(posedge shift_stage_clock) disable iff (!shift_rst_n)
      !shift_fresh |-> serial_cascade_output == $past(shift_stage[`SSPD_LAST_STAGE-1]))
      else $error("cascade output wrong");

   /////////////////////////////////////////////////////////////////////////////
   // system domain: reset release and input synchronisers
   logic rst_s1;
   logic rst_n;
   logic tgl_s1, tgl_s2, tgl_s3;
   logic lat_s1, lat_s2, lat_s3;
   logic clr_s1, clr_s2;
   logic oen_s1, oen_s2;

   // reset is released through two flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1 <= `SSPD_SYNC_IDLE;
         rst_n  <= `SSPD_SYNC_IDLE;
      end else begin
         rst_s1 <= 1'h1;
         rst_n  <= rst_s1;
      end
   end

   // toggle and latch clock: two flops plus one for the edge
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {tgl_s1, tgl_s2, tgl_s3} <= {3{`SSPD_SYNC_IDLE}};
         {lat_s1, lat_s2, lat_s3} <= {3{`SSPD_SYNC_IDLE}};
      end else begin
         {tgl_s1, tgl_s2, tgl_s3} <= {shift_toggle, tgl_s1, tgl_s2};
         {lat_s1, lat_s2, lat_s3} <= {latch_clock, lat_s1, lat_s2};
      end
   end

   // level inputs: clear and output enable; enable idles as off
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {clr_s1, clr_s2} <= {2{`SSPD_SYNC_IDLE}};
         {oen_s1, oen_s2} <= {2{`SSPD_OE_N_IDLE}};
      end else begin
         {clr_s1, clr_s2} <= {shift_clear_n, clr_s1};
         {oen_s1, oen_s2} <= {output_enable_n, oen_s1};
      end
   end

   wire shift_event;
   wire latch_event;
   wire clear_active;
   wire blank_active;

   // edge and level decode from synchronised copies only
   assign shift_event  = tgl_s2 ^ tgl_s3;
   assign latch_event  = lat_s2 & ~lat_s3;
   assign clear_active = ~clr_s2;
   assign blank_active = oen_s2;

   /////////////////////////////////////////////////////////////////////////////
   // mirror of the shift stage on the system clock
   sspd_pkg::sspd_word_t mirror;
   sspd_pkg::sspd_word_t next_mirror;

   // word is sampled only after the toggle has settled through two flops;
   // limitation: shift clock period must exceed four system clock periods
   assign next_mirror = clear_active ? `SSPD_ZERO_WORD :
                        shift_event  ? shift_stage : mirror;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mirror <= `SSPD_ZERO_WORD;
      end else begin
         mirror <= next_mirror;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // latch fifo: queues latch events while clear stalls the storage stage
   sspd_pkg::sspd_word_t fifo_data;
   wire                  fifo_valid;
   wire                  fifo_in_ready;
   wire                  storage_take;

   // storage only accepts words while clear is released
   assign storage_take = fifo_valid & ~clear_active;

   sspd_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH)
   ) u_latch_fifo (
      .clk       (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (latch_event),
      .in_ready  (fifo_in_ready),
      .in_data   (mirror),
      .out_valid (fifo_valid),
      .out_ready (~clear_active),
      .out_data  (fifo_data)
   );

   // a latch edge while full is dropped; ready warns the controller
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_ready <= `SSPD_SYNC_IDLE;
      end else begin
         latch_ready <= fifo_in_ready;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // storage stage and output buffer
   sspd_pkg::sspd_word_t storage;
   sspd_pkg::sspd_word_t next_storage;
   sspd_pkg::sspd_word_t next_buffer;

   // clear does not touch storage; it only stalls new words
   assign next_storage = storage_take ? fifo_data : storage;
   // enable high blanks every bit, low lets storage through
   assign next_buffer  = blank_active ? `SSPD_ZERO_WORD : next_storage;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         storage <= `SSPD_ZERO_WORD;
      end else begin
         storage <= next_storage;
      end
   end

   // open drain: drive stays low, enable set turns the sink on
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sink_output.drive  <= `SSPD_ZERO_WORD;
         sink_output.enable <= `SSPD_ZERO_WORD;
      end else begin
         sink_output.drive  <= `SSPD_ZERO_WORD;
         sink_output.enable <= next_buffer;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // checks on the system side
   sequence latch_seen_s;
      latch_event && fifo_in_ready && !fifo_valid;
   endsequence

   sequence word_stored_s;
      ##1 fifo_valid ##1 ($past(clear_active) || storage == $past(fifo_data));
   endsequence

   // a latch into an empty fifo reaches storage two edges later
   latch_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      latch_seen_s |-> word_stored_s)
      else $error("latched word not stored");

   // nothing moves into storage while clear is active
   clear_keeps_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clear_active |=> storage == $past(storage))
      else $error("storage changed under clear");

   // words pass on only with clear released
   pass_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (fifo_valid && !clear_active) |=> storage == $past(fifo_data))
      else $error("storage missed a pending word");

   // enable high blanks all sinks on the next edge
   blank_sinks_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      blank_active |=> sink_output.enable == `SSPD_ZERO_WORD)
      else $error("sink on while blanked");

   // enable low shows the storage word on the next edge
   follow_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !blank_active |=> sink_output.enable == storage)
      else $error("buffer not following storage");

   // a sink is on only where its buffer bit is high; never driven high
   sink_polarity_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ##1 ((sink_output.enable & ~storage) == `SSPD_ZERO_WORD) && (sink_output.drive == `SSPD_ZERO_WORD))
      else $error("sink on for a low bit");

   // mirror empties under clear
   mirror_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clear_active |=> mirror == `SSPD_ZERO_WORD)
      else $error("mirror not cleared");

   // a full fifo withholds ready on the next edge
   full_backpressure_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !fifo_in_ready |=> !latch_ready)
      else $error("ready while full");

endmodule // sspd_driver

`default_nettype wire

/* sim/sspd_ctrl_model.sv */
// controller model that drives the serial link of the sink driver
`timescale 1ns/1ps
`default_nettype none
module sspd_ctrl_model (
   // control timing reference
   input  wire logic sys_clk,
   // link toward the driver
   output logic      shift_stage_clock,
   output logic      serial_input,
   output logic      latch_clock,
   output logic      shift_clear_n,
   output logic      output_enable_n
);
   // link idles with clock low, outputs disabled, clear released
   initial begin
      shift_stage_clock = 1'h0;
      serial_input = 1'h0;
      latch_clock = 1'h0;
      shift_clear_n = 1'h1;
      output_enable_n = 1'h1;
   end
   // one 30 ns link period, clock only runs inside the bit;
   // odd setup offset keeps link edges off the system clock edges
   task automatic shift_bit(input logic b);
      serial_input = b;
      #10.7 shift_stage_clock = 1'h1;
      #10 serial_input = ~b; // hold expired, so show a changed level
      #5 shift_stage_clock = 1'h0;
      #4.3;
   endtask
   // latch pulse, high and low four system cycles each
   task automatic latch();
      @(negedge sys_clk) latch_clock = 1'h1;
      repeat (4) @(negedge sys_clk);
      latch_clock = 1'h0;
      repeat (4) @(negedge sys_clk);
   endtask
   // level controls change at the falling edge
   task automatic set_clear(input logic v);
      @(negedge sys_clk) shift_clear_n = v;
   endtask
   task automatic set_oe(input logic v);
      @(negedge sys_clk) output_enable_n = v;
   endtask
endmodule // sspd_ctrl_model
`default_nettype wire

/* sim/serial_to_parallel_sink_driver_tb_top.sv */
// self-checking bench of the serial-to-parallel sink driver
`timescale 1ns/1ps
`default_nettype none
module serial_to_parallel_sink_driver_tb_top;
   logic                 sys_clk, resetn, shift_stage_clock, serial_input, latch_clock;
   logic                 shift_clear_n, output_enable_n, serial_cascade_output, latch_ready;
   sspd_pkg::sspd_sink_t sink_output;
   sspd_pkg::sspd_word_t shadow, stored, w;
   logic [15:0]          lfsr;
   int                   errors, num_checks;
   const sspd_pkg::sspd_word_t corner [4] = '{8'h00, 8'hFF, 8'h01, 8'h80};

   initial sys_clk = 1'h0;
   always #2.5 sys_clk = ~sys_clk;

   sspd_driver dut_u (.sys_clk(sys_clk), .resetn(resetn), .shift_stage_clock(shift_stage_clock),
      .serial_input(serial_input), .latch_clock(latch_clock), .shift_clear_n(shift_clear_n),
      .output_enable_n(output_enable_n), .serial_cascade_output(serial_cascade_output),
      .latch_ready(latch_ready), .sink_output(sink_output));
   sspd_ctrl_model ctrl_u (.sys_clk(sys_clk), .shift_stage_clock(shift_stage_clock),
      .serial_input(serial_input), .latch_clock(latch_clock), .shift_clear_n(shift_clear_n),
      .output_enable_n(output_enable_n));

   ////////////////////////////////////////////////////////////////////////////
   // expectation helpers
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic sspd_pkg::sspd_word_t shift_model(input sspd_pkg::sspd_word_t s, input logic b);
      return {s[6:0], b};
   endfunction
   task automatic chk_word(input sspd_pkg::sspd_word_t got, input sspd_pkg::sspd_word_t exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({7'h00, got}, {7'h00, exp});
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // msb first, so bit n ends in stage n; cascade checked after every edge
   task automatic shift_word(input sspd_pkg::sspd_word_t v);
      for (int i = 7; i >= 0; i--) begin
         ctrl_u.shift_bit(v[i]);
         if (shift_clear_n) shadow = shift_model(shadow, v[i]);
         chk_bit(serial_cascade_output, shadow[7]);
      end
   endtask
   // bounded wait for room in the latch queue, then one latch event
   task automatic do_latch();
      int n;
      for (n = 0; n < 60 && latch_ready !== 1'h1; n++) @(negedge sys_clk);
      if (latch_ready !== 1'h1) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, latch_ready, 1'h1);
         finish_test();
      end
      repeat (5) @(negedge sys_clk); // mirror needs time after the last shift edge
      ctrl_u.latch();
      repeat (6) @(negedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      errors = 0;
      num_checks = 0;
      lfsr = 16'h03A0;
      shadow = 8'h00;
      stored = 8'h00;
      resetn = 1'h0;
      repeat (2) @(negedge sys_clk);
      resetn = 1'h1;
      chk_word(sink_output.enable, 8'h00);
      ctrl_u.set_oe(1'h0);
      // corner words first, then random ones
      for (int k = 0; k < 10; k++) begin
         lfsr = lfsr_next(lfsr);
         w = (k < 4) ? corner[k] : lfsr[7:0];
         shift_word(w);
         chk_word(sink_output.enable, stored);
         do_latch();
         stored = w;
         chk_word(sink_output.enable, w);
         chk_word(sink_output.drive, 8'h00);
      end
      $display("test data path done");
      // blanking and restore
      ctrl_u.set_oe(1'h1);
      repeat (6) @(negedge sys_clk);
      chk_word(sink_output.enable, 8'h00);
      ctrl_u.set_oe(1'h0);
      repeat (6) @(negedge sys_clk);
      chk_word(sink_output.enable, stored);
      $display("test output enable done");
      // clear without a shift edge, shifts refused, latches queued
      shift_word(8'hA5);
      ctrl_u.set_clear(1'h0);
      #1 shadow = 8'h00;
      chk_bit(serial_cascade_output, 1'h0);
      shift_word(8'hFF);
      for (int k = 0; k < 8; k++) do_latch();
      chk_bit(latch_ready, 1'h0);
      chk_word(sink_output.enable, stored);
      ctrl_u.latch();
      ctrl_u.set_clear(1'h1);
      repeat (30) @(negedge sys_clk);
      stored = 8'h00;
      chk_word(sink_output.enable, stored);
      chk_bit(latch_ready, 1'h1);
      $display("test clear and queue done");
      finish_test();
   end
endmodule // serial_to_parallel_sink_driver_tb_top
`default_nettype wire
